// >>> wsc_pkg.sv
// constants, field layouts and types of the weighing status and calibration command block
package wsc_pkg;

    // ========================================================================
    // command numbers and answer codes
    localparam logic [15:0] CMD_ENTER_CAL = 16'h2329;
    localparam logic [15:0] CMD_SCALE_INTERVAL = 16'h232a;
    localparam logic [15:0] CMD_CAPACITY = 16'h232b;
    localparam logic [15:0] CMD_TEST_MASS = 16'h232c;
    localparam logic [7:0] ERR_NONE = 8'h00;
    localparam logic [7:0] ERR_REFUSED = 8'h63;
    localparam logic [7:0] ASSIST_NONE = 8'h00;
    localparam logic [7:0] ASSIST_RANGE = 8'h01;
    localparam logic [7:0] ASSIST_STATE = 8'h02;
    localparam logic [31:0] SETTING_MIN = 32'h00000001;
    localparam logic [31:0] SETTING_MAX = 32'h0001869f;
    localparam logic [2:0] STATIONS_FOUR = 3'h4;
    localparam logic [2:0] STATIONS_TWO = 3'h2;

    // ========================================================================
    // register offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_INTERVAL = 8'h08;
    localparam logic [7:0] OFS_CAPACITY = 8'h0c;
    localparam logic [7:0] OFS_TEST_MASS = 8'h10;
    localparam logic [7:0] OFS_LAST_RESULT = 8'h14;

    // ========================================================================
    // field positions
    localparam int CTRL_STATIONS_LSB = 0;
    localparam int CTRL_ABORT_BIT = 4;
    localparam int CTRL_COMMIT_BIT = 5;
    localparam int STATUS_STEP_LSB = 0;
    localparam int STATUS_READY_BIT = 8;
    localparam int STATUS_RESP_BIT = 9;

    // ========================================================================
    // reset values
    localparam logic [2:0] RST_STATIONS = 3'h4;
    localparam logic [31:0] RST_INTERVAL = 32'h00000001;
    localparam logic [31:0] RST_CAPACITY = 32'h0001869f;
    localparam logic [31:0] RST_TEST_MASS = 32'h0001869f;

    // ========================================================================
    // types
    typedef struct packed {
        logic weigh_over;
        logic hold;
        logic discharge;
        logic sequence_error;
        logic abnormal_weight;
        logic init_complete;
        logic error_condition;
        logic remote_ready;
    } wsc_status_type;

    typedef struct packed {
        logic [7:0] err;
        logic [7:0] assist;
    } wsc_result_type;

    typedef enum logic [4:0] {
        CAL_MEASURE = 5'h01,
        CAL_ENTERED = 5'h02,
        CAL_INTERVAL = 5'h04,
        CAL_CAPACITY = 5'h08,
        CAL_MASS = 5'h10
    } wsc_step_type;

    typedef enum logic [1:0] {
        HS_IDLE = 2'h1,
        HS_DONE = 2'h2
    } wsc_hs_type;

endpackage

// >>> wsc_calib_status.sv
// status bits and calibration command interpreter of the weighing indicator link
// ============================================================================
// Summary of operation
// - weigh over while any over-range flag
// - hold bit follows frozen display
// - discharge bit while gate open
// - sequence error bit while sequence fault
// - abnormal weight on over or zero fault
// - init complete flag unsupported, held low
// - error condition flag follows indicator fault
// - remote ready low until initialization done
// - product code output continuously as BCD
// - calibration only with four or two stations
// - abort discards pending values, restores parameters
// - 9001 with zero enters calibration mode
// - 9001 outside measurement mode gives 99/2
// - 9002 accepts intervals 1,2,5,10,20,50
// - out-of-range operand gives 99/1
// - 9003 capacity accepted from 1 to 99999
// - wrong mode or order gives 99/2
// - 9004 mass 1..99999, not above capacity
// - remote setting indication during calibration
// - response set on completion, dropped after request
// - read/write response bit marks command kind
`timescale 1ns/1ps

module wsc_calib_status #(
    parameter int CODE_DIGITS = 4
) (
    input wire logic clk,
    input wire logic arst_n,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [31:0] reg_rdata,
    // weighing conditions
    input wire logic overload_flag,
    input wire logic overflow_flag,
    input wire logic negative_overload_flag,
    input wire logic negative_overflow_flag,
    input wire logic display_hold,
    input wire logic gate_open,
    input wire logic sequence_fault,
    input wire logic zero_set_fault,
    input wire logic indicator_fault,
    input wire logic init_done,
    input wire logic [4*CODE_DIGITS-1:0] product_code,
    // link side
    input wire logic command_request,
    input wire logic [15:0] command_word_four_station,
    input wire logic [15:0] command_word_two_station,
    input wire logic [31:0] operand_words_four_station,
    input wire logic [31:0] operand_words_two_station,
    output logic command_response,
    output logic rw_response,
    output wsc_pkg::wsc_result_type command_result,
    output wsc_pkg::wsc_status_type status_bits,
    output logic [4*CODE_DIGITS-1:0] product_code_out,
    output logic remote_setting_indication
);
    import wsc_pkg::*;

    initial begin
        if (CODE_DIGITS < 1 || CODE_DIGITS > 8) begin
            $error("CODE_DIGITS must lie in 1..8");
        end
    end

    // ========================================================================
    // decoding helpers
    function automatic logic interval_ok(input logic [31:0] v);
        interval_ok = (v == 32'h00000001) || (v == 32'h00000002) || (v == 32'h00000005)
            || (v == 32'h0000000a) || (v == 32'h00000014) || (v == 32'h00000032);
    endfunction

    function automatic logic in_setting_range(input logic [31:0] v);
        in_setting_range = (v >= SETTING_MIN) && (v <= SETTING_MAX);
    endfunction

    // ========================================================================
    // state
    wsc_hs_type hs_state;
    wsc_step_type step;
    logic [2:0] stations;
    logic [31:0] pend_interval;
    logic [31:0] pend_capacity;
    logic [31:0] pend_mass;
    logic [31:0] act_interval;
    logic [31:0] act_capacity;
    logic [31:0] act_mass;

    // ========================================================================
    // command selection and checking
    wire four_station = (stations == STATIONS_FOUR);
    wire two_station = (stations == STATIONS_TWO);
    wire link_cal_ok = four_station || two_station;
    wire [15:0] cmd_word = four_station ? command_word_four_station
        : command_word_two_station;
    wire [31:0] operand = four_station ? operand_words_four_station
        : operand_words_two_station;
    wire cmd_take = (hs_state == HS_IDLE) && command_request;
    wire in_cal = (step != CAL_MEASURE);

    wire ctrl_hit = reg_write && (reg_addr == OFS_CTRL);
    wire abort_req = ctrl_hit && reg_wdata[CTRL_ABORT_BIT];
    wire commit_req = ctrl_hit && reg_wdata[CTRL_COMMIT_BIT] && (step == CAL_MASS);

    wsc_result_type result;
    wsc_step_type next_step;
    logic load_interval;
    logic load_capacity;
    logic load_mass;

    always_comb begin
        result = '{err: ERR_NONE, assist: ASSIST_NONE};
        next_step = step;
        load_interval = 1'b0;
        load_capacity = 1'b0;
        load_mass = 1'b0;
        if (!link_cal_ok) begin
            result = '{err: ERR_REFUSED, assist: ASSIST_STATE};
        end else begin
            unique case (cmd_word)
                CMD_ENTER_CAL: begin
                    if (in_cal) begin
                        result = '{err: ERR_REFUSED, assist: ASSIST_STATE};
                    end else if (operand != 32'h00000000) begin
                        result = '{err: ERR_REFUSED, assist: ASSIST_RANGE};
                    end else begin
                        next_step = CAL_ENTERED;
                    end
                end
                CMD_SCALE_INTERVAL: begin
                    if (!in_cal) begin
                        result = '{err: ERR_REFUSED, assist: ASSIST_STATE};
                    end else if (!interval_ok(operand)) begin
                        result = '{err: ERR_REFUSED, assist: ASSIST_RANGE};
                    end else begin
                        load_interval = 1'b1;
                        next_step = CAL_INTERVAL;
                    end
                end
                CMD_CAPACITY: begin
                    if (step == CAL_MEASURE || step == CAL_ENTERED) begin
                        result = '{err: ERR_REFUSED, assist: ASSIST_STATE};
                    end else if (!in_setting_range(operand)) begin
                        result = '{err: ERR_REFUSED, assist: ASSIST_RANGE};
                    end else begin
                        load_capacity = 1'b1;
                        next_step = CAL_CAPACITY;
                    end
                end
                CMD_TEST_MASS: begin
                    if (step != CAL_CAPACITY && step != CAL_MASS) begin
                        result = '{err: ERR_REFUSED, assist: ASSIST_STATE};
                    end else if (!in_setting_range(operand) || operand > pend_capacity) begin
                        result = '{err: ERR_REFUSED, assist: ASSIST_RANGE};
                    end else begin
                        load_mass = 1'b1;
                        next_step = CAL_MASS;
                    end
                end
                default: begin
                    result = '{err: ERR_REFUSED, assist: ASSIST_STATE};
                end
            endcase
        end
    end

    // ========================================================================
    // general command handshake
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            hs_state <= HS_IDLE;
            command_response <= 1'b0;
            rw_response <= 1'b0;
            command_result <= '0;
        end else begin
            unique case (hs_state)
                HS_IDLE: begin
                    if (cmd_take) begin
                        hs_state <= HS_DONE;
                        command_response <= 1'b1;
                        rw_response <= 1'b0;
                        command_result <= result;
                    end
                end
                HS_DONE: begin
                    if (!command_request) begin
                        hs_state <= HS_IDLE;
                        command_response <= 1'b0;
                    end
                end
            endcase
        end
    end

    // ========================================================================
    // calibration progress and settings
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            step <= CAL_MEASURE;
        end else if (abort_req || commit_req) begin
            step <= CAL_MEASURE;
        end else if (cmd_take) begin
            step <= next_step;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pend_interval <= RST_INTERVAL;
            pend_capacity <= RST_CAPACITY;
            pend_mass <= RST_TEST_MASS;
        end else if (abort_req || (cmd_take && next_step == CAL_ENTERED && !in_cal)) begin
            pend_interval <= act_interval;
            pend_capacity <= act_capacity;
            pend_mass <= act_mass;
        end else if (cmd_take) begin
            if (load_interval) begin
                pend_interval <= operand;
            end
            if (load_capacity) begin
                pend_capacity <= operand;
            end
            if (load_mass) begin
                pend_mass <= operand;
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            act_interval <= RST_INTERVAL;
            act_capacity <= RST_CAPACITY;
            act_mass <= RST_TEST_MASS;
        end else if (commit_req && !abort_req) begin
            act_interval <= pend_interval;
            act_capacity <= pend_capacity;
            act_mass <= pend_mass;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            stations <= RST_STATIONS;
        end else if (ctrl_hit) begin
            stations <= reg_wdata[CTRL_STATIONS_LSB +: 3];
        end
    end

    // ========================================================================
    // status toward the master
    wire any_over = overload_flag || overflow_flag || negative_overload_flag
        || negative_overflow_flag;

    // indication tracks the step that the coming edge will load into step
    wsc_step_type next_ind_step;
    assign next_ind_step = (abort_req || commit_req) ? CAL_MEASURE
        : (cmd_take ? next_step : step);

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            status_bits <= '0;
            product_code_out <= '0;
            remote_setting_indication <= 1'b0;
        end else begin
            status_bits.weigh_over <= any_over;
            status_bits.hold <= display_hold;
            status_bits.discharge <= gate_open;
            status_bits.sequence_error <= sequence_fault;
            status_bits.abnormal_weight <= any_over || zero_set_fault;
            status_bits.init_complete <= 1'b0;
            status_bits.error_condition <= indicator_fault;
            status_bits.remote_ready <= init_done;
            product_code_out <= product_code;
            remote_setting_indication <= (next_ind_step != CAL_MEASURE);
        end
    end

    // ========================================================================
    // register reads
    wire [31:0] status_word = {22'h000000, command_response, status_bits.remote_ready,
        3'h0, step};
    wire [31:0] read_mux = (reg_addr == OFS_CTRL) ? {29'h00000000, stations}
        : (reg_addr == OFS_STATUS) ? status_word
        : (reg_addr == OFS_INTERVAL) ? act_interval
        : (reg_addr == OFS_CAPACITY) ? act_capacity
        : (reg_addr == OFS_TEST_MASS) ? act_mass
        : (reg_addr == OFS_LAST_RESULT) ? {16'h0000, command_result}
        : 32'h00000000;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            reg_rdata <= 32'h00000000;
        end else if (reg_read) begin
            reg_rdata <= read_mux;
        end else begin
            reg_rdata <= 32'h00000000;
        end
    end

endmodule

// >>> wsc_calib_status_asserts.sv
// concurrent checks on the ports of the status and calibration block
`timescale 1ns/1ps
module wsc_calib_status_asserts #(
    parameter int CODE_DIGITS = 4
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic overload_flag,
    input wire logic overflow_flag,
    input wire logic negative_overload_flag,
    input wire logic negative_overflow_flag,
    input wire logic display_hold,
    input wire logic gate_open,
    input wire logic sequence_fault,
    input wire logic zero_set_fault,
    input wire logic indicator_fault,
    input wire logic init_done,
    input wire logic [4*CODE_DIGITS-1:0] product_code,
    input wire logic command_request,
    input wire logic command_response,
    input wire logic rw_response,
    input wsc_pkg::wsc_status_type status_bits,
    input wire logic [4*CODE_DIGITS-1:0] product_code_out
);
    import wsc_pkg::*;
    wire over_any = overload_flag | overflow_flag | negative_overload_flag | negative_overflow_flag;
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    // ========================================================================
    // general command handshake
    sequence req_taken;
        command_request && !command_response;
    endsequence
    sequence req_released;
        command_response && !command_request;
    endsequence
    // an output copies its input one cycle later, once out of reset
    property follows(logic o, logic i);
        $past(arst_n) |-> o == $past(i);
    endproperty
    resp_rise_a: assert property (req_taken |=> command_response)
        else $error("response did not follow request");
    resp_hold_a: assert property (command_response && command_request |=> command_response)
        else $error("response dropped while request high");
    resp_drop_a: assert property (req_released |=> !command_response)
        else $error("response kept after request low");
    resp_idle_a: assert property (!command_request && !command_response |=> !command_response)
        else $error("response without request");
    rw_write_a: assert property (command_response |-> !rw_response)
        else $error("write command reported as read");
    // ========================================================================
    // status bits
    over_flag_a: assert property (follows(status_bits.weigh_over, over_any))
        else $error("weigh over bit wrong");
    hold_bit_a: assert property (follows(status_bits.hold, display_hold))
        else $error("hold bit wrong");
    gate_bit_a: assert property (follows(status_bits.discharge, gate_open))
        else $error("discharge bit wrong");
    seq_err_a: assert property (follows(status_bits.sequence_error, sequence_fault))
        else $error("sequence error bit wrong");
    abnormal_bit_a: assert property (follows(status_bits.abnormal_weight, over_any | zero_set_fault))
        else $error("abnormal weight bit wrong");
    init_flag_a: assert property (status_bits.init_complete == 1'b0)
        else $error("init complete flag set");
    err_flag_a: assert property (follows(status_bits.error_condition, indicator_fault))
        else $error("error condition bit wrong");
    ready_bit_a: assert property (follows(status_bits.remote_ready, init_done))
        else $error("remote ready bit wrong");
    code_out_a: assert property ($past(arst_n) |-> product_code_out == $past(product_code))
        else $error("product code not passed on");
endmodule

// >>> wsc_master_model.sv
// master station model issuing general commands over the handshake
`timescale 1ns/1ps
module wsc_master_model (
    input wire logic clk,
    input wire logic command_response,
    input wsc_pkg::wsc_result_type command_result,
    output logic command_request,
    output logic [15:0] command_word_four_station,
    output logic [15:0] command_word_two_station,
    output logic [31:0] operand_words_four_station,
    output logic [31:0] operand_words_two_station
);
    import wsc_pkg::*;
    initial begin
        command_request = 1'b0;
        {command_word_four_station, command_word_two_station} = 32'h0;
        {operand_words_four_station, operand_words_two_station} = 64'h0;
    end
    // one command; the unused word set carries inverted junk, lag holds the request longer
    task automatic issue(input logic two, input logic [15:0] c, input logic [31:0] o,
                         input int lag, output wsc_result_type res);
        int n;
        @(posedge clk);
        command_request <= 1'b1;
        command_word_two_station <= two ? c : ~c;
        command_word_four_station <= two ? ~c : c;
        operand_words_two_station <= two ? o : ~o;
        operand_words_four_station <= two ? ~o : o;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (command_response !== 1'b1 && n < 20);
        res = command_result;
        repeat (lag) @(posedge clk);
        command_request <= 1'b0;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (command_response !== 1'b0 && n < 20);
        {command_word_four_station, command_word_two_station} <=
            ~{command_word_four_station, command_word_two_station};
        {operand_words_four_station, operand_words_two_station} <=
            ~{operand_words_four_station, operand_words_two_station};
    endtask
endmodule

// >>> test_wsc_calib_status.sv
// self-checking bench of the status bits and calibration commands
`timescale 1ns/1ps
module test_wsc_calib_status;
    import wsc_pkg::*;
    localparam logic [15:0] OK = 16'h0000;
    localparam logic [15:0] BAD_RANGE = {ERR_REFUSED, ASSIST_RANGE};
    localparam logic [15:0] BAD_STATE = {ERR_REFUSED, ASSIST_STATE};
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_write = 1'b0;
    logic reg_read = 1'b0;
    logic [31:0] reg_rdata;
    logic [9:0] cond = 10'h000;
    logic [15:0] product_code = 16'h0000;
    logic command_request;
    logic [15:0] command_word_four_station;
    logic [15:0] command_word_two_station;
    logic [31:0] operand_words_four_station;
    logic [31:0] operand_words_two_station;
    logic command_response;
    logic rw_response;
    logic remote_setting_indication;
    logic [15:0] product_code_out;
    wsc_result_type command_result;
    wsc_status_type status_bits;
    wsc_result_type res;
    logic ok;
    int failures = 0;
    int n_checks = 0;
    int cycles = 0;
    always #25 clk = ~clk;
    wsc_calib_status #(.CODE_DIGITS(4)) u_dut (.clk, .arst_n, .reg_addr, .reg_wdata,
        .reg_write, .reg_read, .reg_rdata, .overload_flag(cond[0]), .overflow_flag(cond[1]),
        .negative_overload_flag(cond[2]), .negative_overflow_flag(cond[3]),
        .display_hold(cond[4]), .gate_open(cond[5]), .sequence_fault(cond[6]),
        .zero_set_fault(cond[7]), .indicator_fault(cond[8]), .init_done(cond[9]),
        .product_code, .command_request, .command_word_four_station, .command_word_two_station,
        .operand_words_four_station, .operand_words_two_station, .command_response,
        .rw_response, .command_result, .status_bits, .product_code_out,
        .remote_setting_indication);
    wsc_master_model u_master (.clk, .command_response, .command_result, .command_request,
        .command_word_four_station, .command_word_two_station, .operand_words_four_station,
        .operand_words_two_station);
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_write <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_write <= 1'b0;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk);
        reg_read <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_read <= 1'b0;
        @(negedge clk);
        check($sformatf("register %h", a), reg_rdata, exp);
    endtask
    task automatic cmd(input logic two, input logic [15:0] c, input logic [31:0] o,
                       input logic [15:0] exp);
        u_master.issue(two, c, o, 0, res);
        check("command result", 32'(res), 32'(exp));
    endtask
    task automatic report_and_stop();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 8000) begin
            failures++;
            report_and_stop();
        end
    end
    initial begin
        repeat (5) @(posedge clk);
        arst_n <= 1'b1;
        rd_chk(OFS_CTRL, 32'(RST_STATIONS));
        rd_chk(OFS_INTERVAL, RST_INTERVAL);
        rd_chk(OFS_CAPACITY, RST_CAPACITY);
        rd_chk(OFS_TEST_MASS, RST_TEST_MASS);
        rd_chk(OFS_STATUS, 32'h1);
        rd_chk(8'h40, 32'h0);
        $display("register reset test done");
        product_code <= 16'h9382;
        for (int i = 0; i <= 10; i++) begin
            cond <= (i < 10) ? 10'(1 << i) : 10'h200;
            repeat (2) @(posedge clk);
            check("status bits", 32'(status_bits), 32'({|cond[3:0], cond[4], cond[5], cond[6],
                |cond[3:0] | cond[7], 1'b0, cond[8], cond[9]}));
        end
        check("product code", 32'(product_code_out), 32'h9382);
        $display("status test done");
        cmd(1'b0, CMD_SCALE_INTERVAL, 32'h1, BAD_STATE);
        cmd(1'b0, CMD_ENTER_CAL, 32'h1, BAD_RANGE);
        check("indication", 32'(remote_setting_indication), 32'h0);
        cmd(1'b0, CMD_ENTER_CAL, 32'h0, OK);
        check("indication", 32'(remote_setting_indication), 32'h1);
        cmd(1'b0, CMD_ENTER_CAL, 32'h0, BAD_STATE);
        cmd(1'b0, CMD_CAPACITY, 32'ha, BAD_STATE);
        for (int v = 0; v <= 51; v++) begin
            ok = v inside {1, 2, 5, 10, 20, 50};
            cmd(1'b0, CMD_SCALE_INTERVAL, 32'(v), ok ? OK : BAD_RANGE);
        end
        cmd(1'b0, CMD_TEST_MASS, 32'h5, BAD_STATE);
        cmd(1'b0, CMD_CAPACITY, 32'h0, BAD_RANGE);
        cmd(1'b0, CMD_CAPACITY, 32'h186a0, BAD_RANGE);
        cmd(1'b0, CMD_CAPACITY, 32'h3e8, OK);
        cmd(1'b0, CMD_TEST_MASS, 32'h3e9, BAD_RANGE);
        cmd(1'b0, CMD_TEST_MASS, 32'h0, BAD_RANGE);
        cmd(1'b0, CMD_TEST_MASS, 32'h3e8, OK);
        rd_chk(OFS_INTERVAL, RST_INTERVAL);
        reg_wr(OFS_CTRL, 32'h24);
        rd_chk(OFS_INTERVAL, 32'h32);
        rd_chk(OFS_CAPACITY, 32'h3e8);
        rd_chk(OFS_TEST_MASS, 32'h3e8);
        $display("calibration flow test done");
        reg_wr(OFS_CTRL, 32'h2);
        cmd(1'b0, CMD_ENTER_CAL, 32'h0, BAD_STATE);
        cmd(1'b1, CMD_ENTER_CAL, 32'h0, OK);
        cmd(1'b1, CMD_SCALE_INTERVAL, 32'h5, OK);
        u_master.issue(1'b1, CMD_CAPACITY, 32'h4d, 3, res);
        check("slow command result", 32'(res), 32'(OK));
        reg_wr(OFS_CTRL, 32'h12);
        rd_chk(OFS_CAPACITY, 32'h3e8);
        rd_chk(OFS_STATUS, 32'h101);
        check("indication", 32'(remote_setting_indication), 32'h0);
        cmd(1'b1, CMD_SCALE_INTERVAL, 32'h2, BAD_STATE);
        $display("abort test done");
        reg_wr(OFS_CTRL, 32'h3);
        cmd(1'b0, CMD_ENTER_CAL, 32'h0, BAD_STATE);
        $display("station count test done");
        report_and_stop();
    end
endmodule
bind wsc_calib_status wsc_calib_status_asserts #(.CODE_DIGITS(CODE_DIGITS)) u_chk (.clk,
    .arst_n, .overload_flag, .overflow_flag, .negative_overload_flag, .negative_overflow_flag,
    .display_hold, .gate_open, .sequence_fault, .zero_set_fault, .indicator_fault, .init_done,
    .product_code, .command_request, .command_response, .rw_response, .status_bits,
    .product_code_out);
